/* File: verilog/serial_control_register.sv */
// Purpose: control register of a serial unit with AHB-Lite access
// Assumes: status conditions and frame events come from hclk logic
// Notes: zero wait state slave, every response OKAY
//
// Functional notes
// R1: bit 7 gates the transmit-empty interrupt request.
// R2: bit 6 gates both receive-full and receive-error requests.
// R3: transmitter runs only while bit 5 is set.
// R4: receiver runs only while bit 4 is set.
// R5: address-wait bit 3 acts only in asynchronous address-frame mode.
// R6: while waiting, frames with address bit 0 are discarded.
// R7: skipped frames set no receive-full, framing or overrun flag.
// R8: frame with address bit 1 clears the wait bit and is kept.
// R9: bit 2 gates the transmit-end interrupt request.
// R10: async code 00 uses internal clock, pin not driven.
// R11: async code 01 uses internal clock, drives bit-rate clock on pin.
// R12: async code 10 takes pin clock at sixteen times bit rate.
// R13: sync code 00 uses internal clock and drives it on pin.
// R14: sync code 10 makes the pin a clock input.
// R15: software must not program the reserved clock codes.
// R16: mode bit 0 selects asynchronous, 1 clocked synchronous operation.
// R17: requests follow condition and enable; control resets to zero.
`default_nettype none
module serial_control_register (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic sync_mode,
  input wire logic addr_frame_mode,
  input wire logic tx_empty_cond,
  input wire logic rx_full_cond,
  input wire logic rx_error_cond,
  input wire logic tx_done_cond,
  input wire logic frame_done,
  input wire logic frame_mpb,
  input wire logic frame_err,
  input wire logic frame_overrun,
  input wire logic bit_clk,
  input wire logic xfer_clk,
  input wire logic serial_clk_pin_in,
  output logic serial_clk_pin_out,
  output logic serial_clk_pin_oe,
  output logic ext_clk,
  output logic use_internal,
  output logic tx_on,
  output logic rx_on,
  output logic rx_full_flag_set,
  output logic frame_err_flag_set,
  output logic overrun_flag_set,
  output logic tx_empty_irq,
  output logic rx_full_irq,
  output logic rx_error_irq,
  output logic tx_done_irq,
  output logic irq
);
  import scr_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [EVT_W-1:0] ists;
    logic [EVT_W-1:0] imask;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic tx_empty_irq;
    logic rx_full_irq;
    logic rx_error_irq;
    logic tx_done_irq;
    logic irq;
    logic rx_full_set;
    logic ferr_set;
    logic ovr_set;
  } top_s;
  top_s st_reg, st_next;
  logic keep, wake, sel_reserved;
  logic addr_ph;
  logic [EVT_W-1:0] evt;

  function automatic logic [31:0] read_mux(input top_s s, input logic [7:0] a,
                                           input logic rsvd);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      OFS_CTRL: r[7:0] = s.ctrl;
      OFS_IRQ_STATUS: r[EVT_W-1:0] = s.ists;
      OFS_IRQ_MASK: r[EVT_W-1:0] = s.imask;
      OFS_PIN_STATUS: r[0] = rsvd;
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // sub blocks
  // ----------------------------------------------------------------
  addr_frame_filter u_filter (
    .wait_bit(st_reg.ctrl[BIT_ADDR_WAIT]),
    .sync_mode(sync_mode),
    .addr_frame_mode(addr_frame_mode),
    .frame_done(frame_done),
    .frame_mpb(frame_mpb),
    .keep(keep),
    .wake(wake)
  );
  clk_pin_ctrl u_pin (
    .hclk(hclk),
    .hresetn(hresetn),
    .sync_mode(sync_mode),
    .clk_sel(st_reg.ctrl[BIT_CLK_SEL_HI:BIT_CLK_SEL_LO]),
    .bit_clk(bit_clk),
    .xfer_clk(xfer_clk),
    .pin_in(serial_clk_pin_in),
    .pin_out(serial_clk_pin_out),
    .pin_oe(serial_clk_pin_oe),
    .ext_clk(ext_clk),
    .use_internal(use_internal),
    .sel_reserved(sel_reserved)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    addr_ph = hsel & hready & (htrans == HTRANS_NONSEQ);
    st_next.wr_pend = addr_ph & hwrite;
    if (addr_ph) begin
      st_next.wr_addr = haddr;
    end
    if (addr_ph && !hwrite) begin
      st_next.rdata = read_mux(st_reg, haddr, sel_reserved);
    end
    if (st_reg.wr_pend) begin
      unique case (st_reg.wr_addr)
        OFS_CTRL: st_next.ctrl = hwdata[7:0];
        OFS_IRQ_STATUS: st_next.ists = st_reg.ists & ~hwdata[EVT_W-1:0];
        OFS_IRQ_MASK: st_next.imask = hwdata[EVT_W-1:0];
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end
    if (wake) begin
      st_next.ctrl[BIT_ADDR_WAIT] = 1'b0; // R8
    end
    st_next.tx_empty_irq = tx_empty_cond & st_reg.ctrl[BIT_TX_EMPTY_IRQ_EN]; // R1 R17
    st_next.rx_full_irq = rx_full_cond & st_reg.ctrl[BIT_RX_IRQ_EN]; // R2 R17
    st_next.rx_error_irq = rx_error_cond & st_reg.ctrl[BIT_RX_IRQ_EN]; // R2 R17
    st_next.tx_done_irq = tx_done_cond & st_reg.ctrl[BIT_TX_DONE_IRQ_EN]; // R9 R17
    st_next.rx_full_set = keep & st_reg.ctrl[BIT_RX_ON] & ~frame_err & ~frame_overrun; // R4 R7
    st_next.ferr_set = keep & st_reg.ctrl[BIT_RX_ON] & frame_err; // R7
    st_next.ovr_set = keep & st_reg.ctrl[BIT_RX_ON] & frame_overrun; // R7
    evt = '0;
    evt[EVT_TX_EMPTY] = st_next.tx_empty_irq & ~st_reg.tx_empty_irq;
    evt[EVT_RX_FULL] = st_next.rx_full_irq & ~st_reg.rx_full_irq;
    evt[EVT_RX_ERROR] = st_next.rx_error_irq & ~st_reg.rx_error_irq;
    evt[EVT_TX_DONE] = st_next.tx_done_irq & ~st_reg.tx_done_irq;
    evt[EVT_ADDR_WAKE] = wake;
    // set wins over write-one-to-clear
    st_next.ists = st_next.ists | evt;
    st_next.irq = |(st_next.ists & st_next.imask);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0; // R17
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = st_reg.rdata;
  assign tx_on = st_reg.ctrl[BIT_TX_ON]; // R3
  assign rx_on = st_reg.ctrl[BIT_RX_ON]; // R4
  assign rx_full_flag_set = st_reg.rx_full_set;
  assign frame_err_flag_set = st_reg.ferr_set;
  assign overrun_flag_set = st_reg.ovr_set;
  assign tx_empty_irq = st_reg.tx_empty_irq;
  assign rx_full_irq = st_reg.rx_full_irq;
  assign rx_error_irq = st_reg.rx_error_irq;
  assign tx_done_irq = st_reg.tx_done_irq;
  assign irq = st_reg.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_txe_gate;
    tx_empty_irq |-> $past(tx_empty_cond) && $past(st_reg.ctrl[BIT_TX_EMPTY_IRQ_EN]);
  endproperty
  a_txe_gate: assert property (p_txe_gate) else $error("tx empty req not gated"); // R1
  property p_rx_gate;
    (rx_full_irq || rx_error_irq) |-> $past(st_reg.ctrl[BIT_RX_IRQ_EN]);
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx req not gated"); // R2
  property p_rx_follow;
    (rx_error_cond && st_reg.ctrl[BIT_RX_IRQ_EN]) |=> rx_error_irq;
  endproperty
  a_rx_follow: assert property (p_rx_follow) else $error("rx error req missing"); // R2 R17
  property p_tx_on;
    st_reg.wr_pend && st_reg.wr_addr == OFS_CTRL |=> tx_on == $past(hwdata[BIT_TX_ON]);
  endproperty
  a_tx_on: assert property (p_tx_on) else $error("tx enable not taken"); // R3
  property p_rx_off;
    !rx_on |=> !rx_full_flag_set && !frame_err_flag_set && !overrun_flag_set;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("flag set with rx off"); // R4
  property p_skip;
    (frame_done && !frame_mpb && !sync_mode && addr_frame_mode
     && st_reg.ctrl[BIT_ADDR_WAIT]) |=> !rx_full_flag_set && !frame_err_flag_set
     && !overrun_flag_set;
  endproperty
  a_skip: assert property (p_skip) else $error("skipped frame set a flag"); // R6 R7
  property p_no_filter;
    (frame_done && rx_on && (sync_mode || !addr_frame_mode) && !frame_err
     && !frame_overrun) |=> rx_full_flag_set;
  endproperty
  a_no_filter: assert property (p_no_filter) else $error("frame lost outside filter"); // R5 R16
  property p_wake;
    (frame_done && frame_mpb && !sync_mode && addr_frame_mode
     && st_reg.ctrl[BIT_ADDR_WAIT] && rx_on && !frame_err && !frame_overrun)
    |=> !st_reg.ctrl[BIT_ADDR_WAIT] && rx_full_flag_set && st_reg.ists[EVT_ADDR_WAKE];
  endproperty
  a_wake: assert property (p_wake) else $error("wake frame not handled"); // R8
  property p_tend_gate;
    tx_done_irq |-> $past(tx_done_cond) && $past(st_reg.ctrl[BIT_TX_DONE_IRQ_EN]);
  endproperty
  a_tend_gate: assert property (p_tend_gate) else $error("tx done req not gated"); // R9
  property p_irq_line;
    irq == |(st_reg.ists & st_reg.imask);
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("irq line wrong"); // R17

  // ----------------------------------------------------------------
  // request, flag and register checks
  // ----------------------------------------------------------------
  property p_txe_follow;
    (tx_empty_cond && st_reg.ctrl[BIT_TX_EMPTY_IRQ_EN]) |=> tx_empty_irq;
  endproperty
  a_txe_follow: assert property (p_txe_follow) else $error("tx empty missing"); // R1 R17
  property p_rxf_follow;
    (rx_full_cond && st_reg.ctrl[BIT_RX_IRQ_EN]) |=> rx_full_irq;
  endproperty
  a_rxf_follow: assert property (p_rxf_follow) else $error("rx full missing"); // R2 R17
  property p_tend_follow;
    (tx_done_cond && st_reg.ctrl[BIT_TX_DONE_IRQ_EN]) |=> tx_done_irq;
  endproperty
  a_tend_follow: assert property (p_tend_follow) else $error("tx done missing"); // R9 R17
  property p_rx_on;
    st_reg.wr_pend && st_reg.wr_addr == OFS_CTRL |=> rx_on == $past(hwdata[BIT_RX_ON]);
  endproperty
  a_rx_on: assert property (p_rx_on) else $error("rx enable not taken"); // R4
  property p_ferr_kept;
    (keep && rx_on && frame_err) |=> frame_err_flag_set;
  endproperty
  a_ferr_kept: assert property (p_ferr_kept) else $error("framing flag missing"); // R8
  property p_ovr_kept;
    (keep && rx_on && frame_overrun) |=> overrun_flag_set;
  endproperty
  a_ovr_kept: assert property (p_ovr_kept) else $error("overrun flag missing"); // R8
  property p_wake_wins;
    (wake && st_reg.wr_pend && st_reg.wr_addr == OFS_CTRL) |=> !st_reg.ctrl[BIT_ADDR_WAIT];
  endproperty
  a_wake_wins: assert property (p_wake_wins) else $error("wait bit kept"); // R8
  property p_evt_sets;
    (evt != '0) |=> (st_reg.ists & $past(evt)) == $past(evt);
  endproperty
  a_evt_sets: assert property (p_evt_sets) else $error("status event lost"); // R17
  property p_w1c;
    (st_reg.wr_pend && st_reg.wr_addr == OFS_IRQ_STATUS && evt == '0)
    |=> (st_reg.ists & $past(hwdata[EVT_W-1:0])) == '0;
  endproperty
  a_w1c: assert property (p_w1c) else $error("status not cleared"); // R17
  property p_mask_wr;
    st_reg.wr_pend && st_reg.wr_addr == OFS_IRQ_MASK
    |=> st_reg.imask == $past(hwdata[EVT_W-1:0]);
  endproperty
  a_mask_wr: assert property (p_mask_wr) else $error("mask not taken"); // R17
  property p_ctrl_read;
    (addr_ph && !hwrite && haddr == OFS_CTRL) |=> hrdata == {24'h0, $past(st_reg.ctrl)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl read wrong"); // R17
  c_wake: cover property (frame_done && frame_mpb && st_reg.ctrl[BIT_ADDR_WAIT] ##1 irq);
  c_skip: cover property (frame_done && !frame_mpb && st_reg.ctrl[BIT_ADDR_WAIT]
                          && addr_frame_mode && !sync_mode);
  c_pin_out: cover property (serial_clk_pin_oe ##1 !serial_clk_pin_oe);
  c_w1c: cover property (st_reg.wr_pend && st_reg.wr_addr == OFS_IRQ_STATUS && irq ##1 !irq);
endmodule
`default_nettype wire

/* File: common/scr_pkg.sv */
// Purpose: shared constants for the serial control register block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes: offsets are byte addresses
`default_nettype none
package scr_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [7:0] OFS_PIN_STATUS = 8'h0c;
  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int BIT_TX_EMPTY_IRQ_EN = 7;
  localparam int BIT_RX_IRQ_EN = 6;
  localparam int BIT_TX_ON = 5;
  localparam int BIT_RX_ON = 4;
  localparam int BIT_ADDR_WAIT = 3;
  localparam int BIT_TX_DONE_IRQ_EN = 2;
  localparam int BIT_CLK_SEL_HI = 1;
  localparam int BIT_CLK_SEL_LO = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ----------------------------------------------------------------
  // event status / mask layout
  // ----------------------------------------------------------------
  localparam int EVT_W = 5;
  localparam int EVT_TX_EMPTY = 0;
  localparam int EVT_RX_FULL = 1;
  localparam int EVT_RX_ERROR = 2;
  localparam int EVT_TX_DONE = 3;
  localparam int EVT_ADDR_WAKE = 4;
  localparam logic [EVT_W-1:0] EVT_RESET = 5'h00;
  // ----------------------------------------------------------------
  // clock source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] CLK_SEL_INT = 2'h0;
  localparam logic [1:0] CLK_SEL_INT_OUT = 2'h1;
  localparam logic [1:0] CLK_SEL_EXT = 2'h2;
  localparam logic [1:0] CLK_SEL_RSVD = 2'h3;
  // ----------------------------------------------------------------
  // bus constants
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

/* File: verilog/addr_frame_filter.sv */
// Purpose: decides per received frame whether it is kept or skipped
// Assumes: frame_done is a one-cycle pulse on hclk with its attributes valid
// Notes: purely combinational, the caller registers the results
`default_nettype none
module addr_frame_filter (
  input wire logic wait_bit,
  input wire logic sync_mode,
  input wire logic addr_frame_mode,
  input wire logic frame_done,
  input wire logic frame_mpb,
  output logic keep,
  output logic wake
);
  import scr_pkg::*;
  logic active;
  // ----------------------------------------------------------------
  // filter decision
  // ----------------------------------------------------------------
  always_comb begin
    active = wait_bit & ~sync_mode & addr_frame_mode; // R5 R16
    keep = frame_done & (~active | frame_mpb); // R6 R7
    wake = frame_done & active & frame_mpb; // R8
  end
endmodule
`default_nettype wire

/* File: verilog/clk_pin_ctrl.sv */
// Purpose: serial clock pin direction, drive and input sampling
// Assumes: bit_clk and xfer_clk are levels made on hclk
// Notes: pin input passes two flops before use
`default_nettype none
module clk_pin_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sync_mode,
  input wire logic [1:0] clk_sel,
  input wire logic bit_clk,
  input wire logic xfer_clk,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic ext_clk,
  output logic use_internal,
  output logic sel_reserved
);
  import scr_pkg::*;
  typedef struct packed {
    logic s1;
    logic s2;
    logic out;
    logic oe;
    logic intl;
    logic rsvd;
  } pin_s;
  pin_s st_reg, st_next;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.out = 1'b0;
    st_next.oe = 1'b0;
    st_next.intl = 1'b0;
    st_next.rsvd = 1'b0;
    if (!sync_mode) begin // R16
      unique case (clk_sel)
        CLK_SEL_INT: st_next.intl = 1'b1; // R10
        CLK_SEL_INT_OUT: begin
          st_next.intl = 1'b1; // R11
          st_next.oe = 1'b1;
          st_next.out = bit_clk;
        end
        CLK_SEL_EXT: st_next.intl = 1'b0; // R12
        default: st_next.rsvd = 1'b1;
      endcase
    end else begin
      unique case (clk_sel)
        CLK_SEL_INT: begin
          st_next.intl = 1'b1; // R13
          st_next.oe = 1'b1;
          st_next.out = xfer_clk;
        end
        CLK_SEL_EXT: st_next.intl = 1'b0; // R14
        default: st_next.rsvd = 1'b1;
      endcase
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign pin_out = st_reg.out;
  assign pin_oe = st_reg.oe;
  assign ext_clk = st_reg.s2;
  assign use_internal = st_reg.intl;
  assign sel_reserved = st_reg.rsvd;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_ext_input;
    @(posedge hclk) disable iff (!hresetn)
    (clk_sel == CLK_SEL_EXT) |=> !pin_oe && !use_internal;
  endproperty
  a_ext_input: assert property (p_ext_input) else $error("pin driven with ext clock"); // R12 R14
  property p_async_int_no_drive;
    @(posedge hclk) disable iff (!hresetn)
    (!sync_mode && clk_sel == CLK_SEL_INT) |=> !pin_oe && use_internal;
  endproperty
  a_async_int_no_drive: assert property (p_async_int_no_drive) else $error("pin driven"); // R10
  property p_async_out;
    @(posedge hclk) disable iff (!hresetn)
    (!sync_mode && clk_sel == CLK_SEL_INT_OUT) |=> pin_oe && pin_out == $past(bit_clk);
  endproperty
  a_async_out: assert property (p_async_out) else $error("bit clock not on pin"); // R11
  property p_sync_out;
    @(posedge hclk) disable iff (!hresetn)
    (sync_mode && clk_sel == CLK_SEL_INT) |=> pin_oe && pin_out == $past(xfer_clk);
  endproperty
  a_sync_out: assert property (p_sync_out) else $error("xfer clock not on pin"); // R13
endmodule
`default_nettype wire

/* File: verification/serial_partner.sv */
// Purpose: far-side model, serial clock source and received-frame events
// Assumes: frame events are one-cycle pulses on hclk
// Notes: attributes carry junk outside a frame, clock stands still while not run
`default_nettype none
module serial_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_run,
  output logic pin_drive,
  output logic pin_level,
  output logic frame_done,
  output logic frame_mpb,
  output logic frame_err,
  output logic frame_overrun
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] div_reg;
  // ----------------------------------------------------------------
  // external clock, one pin period per sixteen hclk cycles
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 4'h0;
    end else if (clk_run) begin
      div_reg <= div_reg + 4'h1;
    end
  end
  assign pin_drive = clk_run;
  assign pin_level = div_reg[3];
  // ----------------------------------------------------------------
  // frames
  // ----------------------------------------------------------------
  initial begin
    frame_done = 1'b0;
    frame_mpb = 1'b1;
    frame_err = 1'b1;
    frame_overrun = 1'b1;
  end
  task automatic send(input logic mpb, input logic err, input logic ovr);
    @(posedge hclk);
    frame_done <= 1'b1;
    frame_mpb <= mpb;
    frame_err <= err;
    frame_overrun <= ovr;
    @(posedge hclk);
    frame_done <= 1'b0;
    frame_mpb <= ~mpb;
    frame_err <= ~err;
    frame_overrun <= ~ovr;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Purpose: self-checking bench of the serial control register
// Assumes: zero wait state AHB-Lite slave, partner model on the frame side
// Notes: table loops for control bits and clock pin, hand tests for irq, filter
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import scr_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic sync_mode = 1'b0;
  logic addr_frame_mode = 1'b0;
  logic [3:0] cond = 4'h0;
  logic bit_clk = 1'b0;
  logic xfer_clk = 1'b0;
  logic bit_q = 1'b0;
  logic xfer_q = 1'b0;
  logic float_q = 1'b0;
  logic clk_run = 1'b0;
  wire logic hreadyout, hresp, pin_out, pin_oe, ext_clk, use_internal, tx_on, rx_on, irq;
  wire logic [31:0] hrdata;
  wire logic [2:0] flags;
  wire logic [3:0] req;
  wire logic pin_drive, pin_level, f_done, f_mpb, f_err, f_ovr, pin;
  int errors = 0;
  int tests_run = 0;
  logic [31:0] r;
  logic [2:0] seen;
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) begin
    bit_clk <= ~bit_clk;
    if (bit_clk) xfer_clk <= ~xfer_clk;
    bit_q <= bit_clk;
    xfer_q <= xfer_clk;
    float_q <= ~float_q;
  end
  // undriven pin shows a changing pattern, never a held level
  assign pin = pin_oe ? pin_out : (pin_drive ? pin_level : float_q);
  serial_partner part_u (.hclk(hclk), .hresetn(hresetn), .clk_run(clk_run),
    .pin_drive(pin_drive), .pin_level(pin_level), .frame_done(f_done),
    .frame_mpb(f_mpb), .frame_err(f_err), .frame_overrun(f_ovr));
  serial_control_register dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .sync_mode(sync_mode), .addr_frame_mode(addr_frame_mode),
    .tx_empty_cond(cond[0]), .rx_full_cond(cond[1]), .rx_error_cond(cond[2]),
    .tx_done_cond(cond[3]), .frame_done(f_done), .frame_mpb(f_mpb),
    .frame_err(f_err), .frame_overrun(f_ovr), .bit_clk(bit_clk), .xfer_clk(xfer_clk),
    .serial_clk_pin_in(pin), .serial_clk_pin_out(pin_out), .serial_clk_pin_oe(pin_oe),
    .ext_clk(ext_clk), .use_internal(use_internal), .tx_on(tx_on), .rx_on(rx_on),
    .rx_full_flag_set(flags[0]), .frame_err_flag_set(flags[1]),
    .overrun_flag_set(flags[2]), .tx_empty_irq(req[0]), .rx_full_irq(req[1]),
    .rx_error_irq(req[2]), .tx_done_irq(req[3]), .irq(irq));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    r = hrdata;
    chk({31'h0, hresp}, {31'h0, HRESP_OKAY});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
    @(negedge hclk);
  endtask
  task automatic frame(input logic m, input logic e, input logic o);
    part_u.send(m, e, o);
    seen = 3'h0;
    repeat (3) begin
      @(negedge hclk);
      seen = seen | flags;
    end
  endtask
  typedef struct {logic [7:0] ctrl; logic tx; logic rx;} row_s;
  typedef struct {logic sm; logic [1:0] sel; logic oe; logic ui; logic rsv;} ck_s;
  row_s rows [5] = '{'{8'h20, 1'b1, 1'b0}, '{8'h10, 1'b0, 1'b1}, '{8'hff, 1'b1, 1'b1},
    '{8'hc4, 1'b0, 1'b0}, '{8'h00, 1'b0, 1'b0}};
  ck_s cks [7] = '{'{1'b0, 2'h0, 1'b0, 1'b1, 1'b0}, '{1'b0, 2'h1, 1'b1, 1'b1, 1'b0},
    '{1'b0, 2'h2, 1'b0, 1'b0, 1'b0}, '{1'b1, 2'h0, 1'b1, 1'b1, 1'b0},
    '{1'b1, 2'h2, 1'b0, 1'b0, 1'b0}, '{1'b0, 2'h3, 1'b0, 1'b0, 1'b1},
    '{1'b1, 2'h1, 1'b0, 1'b0, 1'b1}};
  int en_bit [4] = '{BIT_TX_EMPTY_IRQ_EN, BIT_RX_IRQ_EN, BIT_RX_IRQ_EN, BIT_TX_DONE_IRQ_EN};
  initial begin
    #400000;
    errors++;
    conclude();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    r = 32'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      ahb(1'b1, OFS_CTRL, {24'h0, rows[i].ctrl});
      ahb(1'b0, OFS_CTRL, 32'h0);
      chk(r, {24'h0, rows[i].ctrl});
      chk({31'h0, tx_on}, {31'h0, rows[i].tx});
      chk({31'h0, rx_on}, {31'h0, rows[i].rx});
    end
    ahb(1'b0, 8'h10, 32'h0);
    chk(r, RDATA_RESET);
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, OFS_IRQ_MASK, 32'h1 << i);
      cond <= 4'h1 << i;
      cyc(2);
      chk({31'h0, req[i]}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      ahb(1'b1, OFS_CTRL, 32'h1 << en_bit[i]);
      cyc(1);
      chk({31'h0, req[i]}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      ahb(1'b0, OFS_IRQ_STATUS, 32'h0);
      chk(r, 32'h1 << i);
      cond <= 4'h0;
      ahb(1'b1, OFS_IRQ_MASK, 32'h0);
      cyc(1);
      chk({31'h0, req[i]}, 32'h0);
      chk({31'h0, irq}, 32'h0);
      ahb(1'b1, OFS_IRQ_MASK, 32'h1 << i);
      ahb(1'b1, OFS_IRQ_STATUS, 32'h1 << i);
      cyc(1);
      chk({31'h0, irq}, 32'h0);
      ahb(1'b1, OFS_CTRL, 32'h0);
    end
    ahb(1'b1, OFS_IRQ_MASK, 32'h10);
    addr_frame_mode <= 1'b1;
    ahb(1'b1, OFS_CTRL, 32'h18);
    frame(1'b0, 1'b1, 1'b1);
    chk({29'h0, seen}, 32'h0);
    frame(1'b1, 1'b0, 1'b0);
    chk({29'h0, seen}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk(r, 32'h10);
    frame(1'b0, 1'b1, 1'b1);
    chk({29'h0, seen}, 32'h6);
    ahb(1'b1, OFS_CTRL, 32'h18);
    sync_mode <= 1'b1;
    frame(1'b0, 1'b0, 1'b0);
    chk({29'h0, seen}, 32'h1);
    ahb(1'b1, OFS_CTRL, 32'h08);
    frame(1'b0, 1'b0, 1'b0);
    chk({29'h0, seen}, 32'h0);
    foreach (cks[i]) begin
      @(posedge hclk);
      sync_mode <= cks[i].sm;
      clk_run <= ~cks[i].ui & ~cks[i].rsv;
      ahb(1'b1, OFS_CTRL, {30'h0, cks[i].sel});
      ahb(1'b0, OFS_PIN_STATUS, 32'h0);
      chk({31'h0, r[0]}, {31'h0, cks[i].rsv});
      cyc(2);
      chk({31'h0, pin_oe}, {31'h0, cks[i].oe});
      chk({31'h0, use_internal}, {31'h0, cks[i].ui});
      repeat (6) begin
        @(negedge hclk);
        if (cks[i].oe) chk({31'h0, pin_out}, {31'h0, cks[i].sm ? xfer_q : bit_q});
      end
      if (!cks[i].ui && !cks[i].rsv) begin
        @(posedge pin);
        @(negedge hclk);
        chk({31'h0, ext_clk}, 32'h0);
        repeat (2) @(negedge hclk);
        chk({31'h0, ext_clk}, 32'h1);
      end
    end
    ahb(1'b1, OFS_CTRL, 32'hff);
    clk_run <= 1'b0;
    hresetn <= 1'b0;
    cyc(2);
    chk({30'h0, tx_on, rx_on}, 32'h0);
    @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, OFS_CTRL, 32'h0);
    chk(r, {24'h0, CTRL_RESET});
    conclude();
  end
endmodule
`default_nettype wire
